/* File: fhr_drive.sv */
// drive-side supervisor: hour counters, event sorting, fault history, reset
// assumes events come as one-cycle pulses from detection logic in clk_sys
// Function
// - hour counters count 0..65535 and wrap
// - panel shows hours at 0.001 per hour
// - fault trips output, display shows fault
// - error messages display only, no trip
// - warnings display only, no trip
// - alarms no trip, optional alarm output
// - fault trips and asserts fault output
// - keep history of last eight faults
// - reset clears thermal value and retries
// - normal operation resumes 1 s after reset
// - fieldbus reset code triggers full reset
// - fieldbus reset ignored during comm error
// - stop key resets only while tripped
// - power cycle: wait until panel dark
// - aux supply: key or fieldbus reset only
// - start off before issuing fault reset
`timescale 1ns/1ps
module fhr_drive
  import fhr_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = RECOVER_CYC
) (
  input  wire logic   clk_sys,
  input  wire logic   rst,
  fhr_link_if.drive   lnk,
  input  wire logic   hour_tick,
  input  wire logic   running,
  input  wire logic   evt_valid,
  input  wire logic [1:0] evt_class,
  input  wire logic [7:0] evt_code,
  input  wire logic   alarm_en,
  input  wire logic   comm_err,
  input  wire logic   therm_inc,
  input  wire logic   retry_inc,
  input  wire logic [2:0] hist_sel,
  output logic [15:0] energ_hours,
  output logic [15:0] run_hours,
  output logic [12:0] energ_disp,
  output logic [12:0] run_disp,
  output logic [1:0]  disp_mode,
  output logic [7:0]  disp_code,
  output logic [7:0]  hist_code,
  output logic [3:0]  hist_count,
  output logic [15:0] therm_value,
  output logic [7:0]  retry_count
);

  // ***************************************
  // hour accumulation
  // ***************************************
  logic [15:0] energ_r, run_r;
  logic [12:0] edisp_r, rdisp_r;
  logic [3:0]  esub_r, rsub_r;
  logic        in_reset;

  // one shown 0.01 step per ten hours, wraps after the top shown value
  function automatic logic [12:0] disp_step(input logic [12:0] d);
    disp_step = (d == DISP_MAX) ? 13'h0000 : d + 13'h0001;
  endfunction : disp_step

  function automatic logic [3:0] sub_step(input logic [3:0] s);
    sub_step = (s == DISP_STEP_H[3:0] - 4'h1) ? 4'h0 : s + 4'h1;
  endfunction : sub_step

  // hours persist across drive resets; only rst clears them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      energ_r <= 16'h0000;
      esub_r  <= 4'h0;
      edisp_r <= 13'h0000;
    end else if (hour_tick) begin
      energ_r <= energ_r + 16'h0001;
      esub_r  <= sub_step(esub_r);
      if (esub_r == DISP_STEP_H[3:0] - 4'h1) begin
        edisp_r <= disp_step(edisp_r);
      end
      // hour wrap restarts the shown value whatever the sub count is
      if (energ_r == HOUR_MAX) begin
        esub_r  <= 4'h0;
        edisp_r <= 13'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_r   <= 16'h0000;
      rsub_r  <= 4'h0;
      rdisp_r <= 13'h0000;
    end else if (hour_tick && running && !lnk.tripped) begin
      run_r  <= run_r + 16'h0001;
      rsub_r <= sub_step(rsub_r);
      if (rsub_r == DISP_STEP_H[3:0] - 4'h1) begin
        rdisp_r <= disp_step(rdisp_r);
      end
      if (run_r == HOUR_MAX) begin
        rsub_r  <= 4'h0;
        rdisp_r <= 13'h0000;
      end
    end
  end

  // ***************************************
  // reset sources and sequencing
  // ***************************************
  fhr_state_t  st_r, st_nxt;
  logic [27:0] wait_r;
  logic        bus_rst, key_rst, trip_evt;

  assign trip_evt = evt_valid && (evt_class == FHR_CLS_FAULT);
  assign bus_rst  = lnk.cmd_valid && (lnk.cmd_code == CMD_RESET) && !comm_err;
  assign key_rst  = lnk.stop_key && (st_r == FHR_ST_TRIP);
  assign in_reset = (st_r == FHR_ST_RESET);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FHR_ST_RUN:   if (bus_rst) st_nxt = FHR_ST_RESET;
                    else if (trip_evt) st_nxt = FHR_ST_TRIP;
      FHR_ST_TRIP:  if (bus_rst || key_rst) st_nxt = FHR_ST_RESET;
      FHR_ST_RESET: st_nxt = FHR_ST_WAIT;
      FHR_ST_WAIT:  if (bus_rst) st_nxt = FHR_ST_RESET;
                    else if (wait_r == 28'(RECOVER_CYCLES - 1)) st_nxt = FHR_ST_RUN;
      default:      st_nxt = FHR_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= FHR_ST_WAIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // recovery timer restarts each time the reset pulse is seen
  always_ff @(posedge clk_sys) begin
    if (rst || st_r != FHR_ST_WAIT) begin
      wait_r <= 28'h0000000;
    end else begin
      wait_r <= wait_r + 28'h0000001;
    end
  end

  // link outputs; start interlock is the master's duty
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lnk.tripped   <= 1'b1;
      lnk.fault_out <= 1'b0;
      lnk.alarm_out <= 1'b0;
      lnk.ready     <= 1'b0;
    end else begin
      lnk.tripped   <= (st_nxt != FHR_ST_RUN);
      lnk.fault_out <= (st_nxt == FHR_ST_TRIP);
      lnk.ready     <= (st_nxt == FHR_ST_RUN);
      // a new alarm beats a reset in the same cycle so it is never lost
      if (evt_valid && evt_class == FHR_CLS_ALARM && alarm_en) begin
        lnk.alarm_out <= 1'b1;
      end else if (st_nxt == FHR_ST_RESET) begin
        lnk.alarm_out <= 1'b0;
      end
    end
  end

  // ***************************************
  // display and fault history
  // ***************************************
  logic [1:0] dmode_r;
  logic [7:0] dcode_r;
  logic [7:0] hist_r [HIST_DEPTH];
  logic [2:0] wptr_r;
  logic [3:0] hcnt_r;

  // faults take the display; other classes show only while no fault is up
  always_ff @(posedge clk_sys) begin
    if (rst || in_reset) begin
      dmode_r <= FHR_DISP_MON;
      dcode_r <= 8'h00;
    end else if (trip_evt && st_r == FHR_ST_RUN) begin
      dmode_r <= FHR_DISP_FAULT;
      dcode_r <= evt_code;
    end else if (evt_valid && evt_class != FHR_CLS_FAULT && dmode_r != FHR_DISP_FAULT) begin
      dmode_r <= FHR_DISP_MSG;
      dcode_r <= evt_code;
    end
  end

  // ring of eight; a ninth fault overwrites the oldest slot
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wptr_r <= HIST_PTR_RST;
      hcnt_r <= HIST_CNT_RST;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_r[i] <= 8'h00;
      end
    end else if (trip_evt && st_r == FHR_ST_RUN) begin
      hist_r[wptr_r] <= evt_code;
      wptr_r <= wptr_r + 3'h1;
      if (hcnt_r != 4'(HIST_DEPTH)) begin
        hcnt_r <= hcnt_r + 4'h1;
      end
    end
  end

  // hist_sel 0 is the newest entry
  logic [7:0] hsel_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hsel_r <= 8'h00;
    end else begin
      hsel_r <= hist_r[wptr_r - 3'h1 - hist_sel];
    end
  end

  // ***************************************
  // protective integrators cleared on reset
  // ***************************************
  logic [15:0] therm_r;
  logic [7:0]  retry_r;

  always_ff @(posedge clk_sys) begin
    if (rst || in_reset) begin
      therm_r <= THERM_RST;
      retry_r <= RETRY_RST;
    end else begin
      if (therm_inc && therm_r != 16'hffff) therm_r <= therm_r + 16'h0001;
      if (retry_inc && retry_r != 8'hff) retry_r <= retry_r + 8'h01;
    end
  end

  assign energ_hours = energ_r;
  assign run_hours   = run_r;
  assign energ_disp  = edisp_r;
  assign run_disp    = rdisp_r;
  assign disp_mode   = dmode_r;
  assign disp_code   = dcode_r;
  assign hist_code   = hsel_r;
  assign hist_count  = hcnt_r;
  assign therm_value = therm_r;
  assign retry_count = retry_r;

endmodule : fhr_drive

/* File: fhr_link_if.sv */
// interface joining the drive supervisor and its controlling party
// assumes both ends share clk_sys
`timescale 1ns/1ps
interface fhr_link_if (
  input wire logic clk_sys
);
  logic       cmd_valid;    // one-cycle instruction strobe
  logic [7:0] cmd_code;     // instruction code
  logic       stop_key;     // panel stop key pulse
  logic       start_cmd;    // start command level
  logic       tripped;      // drive output shut off
  logic       fault_out;    // fault output signal
  logic       alarm_out;    // alarm output signal
  logic       ready;        // drive in normal operation

  modport drive (
    input  cmd_valid, cmd_code, stop_key, start_cmd,
    output tripped, fault_out, alarm_out, ready
  );
  modport master (
    output cmd_valid, cmd_code, stop_key, start_cmd,
    input  tripped, fault_out, alarm_out, ready
  );
endinterface : fhr_link_if

/* File: fhr_link_monitor.sv */
// checker on the link between drive and master ends
// assumes one clk_sys and a synchronous active-high rst
`timescale 1ns/1ps
module fhr_link_monitor
  import fhr_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = 20
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       comm_err,
  input wire logic       alarm_evt,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       stop_key,
  input wire logic       start_cmd,
  input wire logic       tripped,
  input wire logic       fault_out,
  input wire logic       alarm_out,
  input wire logic       ready
);
  logic        bus_rst;
  logic        do_rst;
  logic [15:0] wait_r;
  // ****************
  // helper logic
  // ****************
  assign bus_rst = cmd_valid && cmd_code == CMD_RESET;
  assign do_rst  = (bus_rst && !comm_err) || (stop_key && fault_out);
  // cycles since last accepted reset, saturates so it never aliases
  always_ff @(posedge clk_sys) begin
    if (rst || do_rst) wait_r <= 16'h0000;
    else if (wait_r != 16'hffff) wait_r <= wait_r + 16'h0001;
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_RESET_TRIP: assert property (do_rst |=> tripped && !fault_out && (!alarm_out || $past(alarm_evt)) && !ready)
    else $error("accepted reset did not trip the drive");
  AST_ALARM_SET: assert property (alarm_evt |=> alarm_out)
    else $error("enabled alarm event did not raise the alarm output");
  AST_RECOVER: assert property ($rose(ready) |-> wait_r >= RECOVER_CYCLES - 1 && wait_r <= RECOVER_CYCLES + 2)
    else $error("ready rose at the wrong time");
  AST_BUS_IGNORED: assert property (bus_rst && comm_err && ready && !stop_key |=> ready)
    else $error("bus reset taken during comm error");
  AST_KEY_IGNORED: assert property (stop_key && !fault_out && ready && !bus_rst |=> ready)
    else $error("stop key reset without fault");
  AST_FAULT_TRIP: assert property (fault_out |-> tripped && !ready)
    else $error("fault output without trip");
  AST_FAULT_HOLD: assert property (fault_out && !do_rst |=> fault_out)
    else $error("fault output dropped without reset");
  AST_ALARM_HOLD: assert property (alarm_out && !do_rst |=> alarm_out)
    else $error("alarm output dropped without reset");
  AST_START_OFF: assert property (bus_rst || stop_key |-> !start_cmd)
    else $error("reset issued with start on");
endmodule : fhr_link_monitor

/* File: fhr_master.sv */
// controlling-party end: issues reset code or stop key with start interlock
// assumes the drive end sits on the same interface and clock
`timescale 1ns/1ps
module fhr_master
  import fhr_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  fhr_link_if.master lnk,
  input  wire logic req_bus_reset,
  input  wire logic req_key_reset,
  input  wire logic req_start,
  output logic      busy,
  output logic      drive_ready,
  output logic      drive_fault
);

  // ***************************************
  // reset issue with start interlock
  // ***************************************
  logic pend_bus_r, pend_key_r, start_r;

  // a reset waits one cycle with start dropped so the motor does not restart
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_bus_r    <= 1'b0;
      pend_key_r    <= 1'b0;
      start_r       <= 1'b0;
      lnk.cmd_valid <= 1'b0;
      lnk.cmd_code  <= 8'h00;
      lnk.stop_key  <= 1'b0;
    end else begin
      lnk.cmd_valid <= 1'b0;
      lnk.stop_key  <= 1'b0;
      if (req_bus_reset) pend_bus_r <= 1'b1;
      if (req_key_reset) pend_key_r <= 1'b1;
      if (req_bus_reset || req_key_reset || pend_bus_r || pend_key_r) begin
        start_r <= 1'b0;
      end else begin
        start_r <= req_start;
      end
      if (!start_r && pend_bus_r) begin
        lnk.cmd_valid <= 1'b1;
        lnk.cmd_code  <= CMD_RESET;
        pend_bus_r    <= 1'b0;
      end else if (!start_r && pend_key_r) begin
        lnk.stop_key  <= 1'b1;
        pend_key_r    <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy        <= 1'b0;
      drive_ready <= 1'b0;
      drive_fault <= 1'b0;
    end else begin
      busy        <= pend_bus_r || pend_key_r || req_bus_reset || req_key_reset;
      drive_ready <= lnk.ready;
      drive_fault <= lnk.fault_out;
    end
  end

  assign lnk.start_cmd = start_r;

endmodule : fhr_master

/* File: fhr_pkg.sv */
// package for the fault history and reset supervisor
// assumes a single 200 MHz system clock shared by both ends
package fhr_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned HOUR_S          = 3600;
  localparam int unsigned RECOVER_MS      = 1000;
  localparam int unsigned RECOVER_CYC     = CLK_HZ / 1000 * RECOVER_MS;
  localparam logic [15:0] HOUR_MAX        = 16'hffff;
  localparam logic [15:0] DISP_STEP_H     = 16'h000a;   // 0.01 shown step = 10 h
  localparam logic [12:0] DISP_MAX        = 13'h1999;   // 6553 -> 65.53
  localparam logic [7:0]  CMD_RESET       = 8'hfd;
  localparam int unsigned HIST_DEPTH      = 8;
  localparam logic [2:0]  HIST_PTR_RST    = 3'h0;
  localparam logic [3:0]  HIST_CNT_RST    = 4'h0;
  localparam logic [15:0] THERM_RST       = 16'h0000;
  localparam logic [7:0]  RETRY_RST       = 8'h00;

  // event classes
  typedef enum logic [1:0] {
    FHR_CLS_ERRMSG = 2'b00,
    FHR_CLS_WARN   = 2'b01,
    FHR_CLS_ALARM  = 2'b10,
    FHR_CLS_FAULT  = 2'b11
  } fhr_cls_t;

  // panel display selection
  typedef enum logic [1:0] {
    FHR_DISP_MON   = 2'b00,
    FHR_DISP_MSG   = 2'b01,
    FHR_DISP_FAULT = 2'b10
  } fhr_disp_t;

  typedef enum logic [1:0] {
    FHR_ST_RUN   = 2'b00,
    FHR_ST_TRIP  = 2'b01,
    FHR_ST_RESET = 2'b10,
    FHR_ST_WAIT  = 2'b11
  } fhr_state_t;

endpackage : fhr_pkg

/* File: tb.sv */
// self-checking bench joining drive and master ends
// assumes a 200 MHz clk_sys and a short recovery count
`timescale 1ns/1ps
module tb
  import fhr_pkg::*;
;
  localparam int unsigned RC = 20;
  typedef struct {int s; logic [15:0] v;} fhr_note_t;
  logic clk_sys = 0, rst = 1, hour_tick = 0, running = 0, evt_valid = 0, alarm_en = 0;
  logic comm_err = 0, therm_inc = 0, retry_inc = 0, req_bus_reset = 0, req_key_reset = 0, req_start = 0;
  logic [1:0]  evt_class = 0;
  logic [7:0]  evt_code = 0;
  logic [2:0]  hist_sel = 0;
  logic [15:0] energ_hours, run_hours, therm_value;
  logic [12:0] energ_disp, run_disp;
  logic [1:0]  disp_mode;
  logic [7:0]  disp_code, hist_code, retry_count, hq[$];
  logic [3:0]  hist_count;
  logic        busy, drive_ready, drive_fault;
  int          num_errors = 0, checked = 0;
  fhr_note_t   q[$], n;
  event        look;
  string       nm [17] = '{"tripped", "fault_out", "alarm_out", "ready", "energ_hours", "run_hours", "energ_disp",
                           "disp_mode", "disp_code", "hist_code", "hist_count", "therm_value", "retry_count",
                           "run_disp", "drive_ready", "drive_fault", "busy"};
  // ****************
  // design and checker
  // ****************
  fhr_link_if u_fhr_link_if (.clk_sys(clk_sys));
  fhr_drive #(.RECOVER_CYCLES(RC)) u_fhr_drive (.clk_sys(clk_sys), .rst(rst), .lnk(u_fhr_link_if),
    .hour_tick(hour_tick), .running(running), .evt_valid(evt_valid), .evt_class(evt_class),
    .evt_code(evt_code), .alarm_en(alarm_en), .comm_err(comm_err), .therm_inc(therm_inc),
    .retry_inc(retry_inc), .hist_sel(hist_sel), .energ_hours(energ_hours), .run_hours(run_hours),
    .energ_disp(energ_disp), .run_disp(run_disp), .disp_mode(disp_mode), .disp_code(disp_code),
    .hist_code(hist_code), .hist_count(hist_count), .therm_value(therm_value), .retry_count(retry_count));
  fhr_master u_fhr_master (.clk_sys(clk_sys), .rst(rst), .lnk(u_fhr_link_if), .req_bus_reset(req_bus_reset),
    .req_key_reset(req_key_reset), .req_start(req_start), .busy(busy), .drive_ready(drive_ready),
    .drive_fault(drive_fault));
  fhr_link_monitor #(.RECOVER_CYCLES(RC)) u_fhr_link_monitor (.clk_sys(clk_sys), .rst(rst),
    .comm_err(comm_err), .alarm_evt(evt_valid && evt_class == FHR_CLS_ALARM && alarm_en),
    .cmd_valid(u_fhr_link_if.cmd_valid), .cmd_code(u_fhr_link_if.cmd_code),
    .stop_key(u_fhr_link_if.stop_key), .start_cmd(u_fhr_link_if.start_cmd), .tripped(u_fhr_link_if.tripped),
    .fault_out(u_fhr_link_if.fault_out), .alarm_out(u_fhr_link_if.alarm_out), .ready(u_fhr_link_if.ready));
  // free-running clock
  always #2.5 clk_sys = ~clk_sys;
  // ****************
  // scoreboard
  // ****************
  function automatic logic [15:0] obs(int s);
    case (s)
      0: obs = {15'h0, u_fhr_link_if.tripped};
      1: obs = {15'h0, u_fhr_link_if.fault_out};
      2: obs = {15'h0, u_fhr_link_if.alarm_out};
      3: obs = {15'h0, u_fhr_link_if.ready};
      4: obs = energ_hours;
      5: obs = run_hours;
      6: obs = {3'h0, energ_disp};
      7: obs = {14'h0, disp_mode};
      8: obs = {8'h0, disp_code};
      9: obs = {8'h0, hist_code};
      10: obs = {12'h0, hist_count};
      11: obs = therm_value;
      13: obs = {3'h0, run_disp};
      14: obs = {15'h0, drive_ready};
      15: obs = {15'h0, drive_fault};
      16: obs = {15'h0, busy};
      default: obs = {8'h0, retry_count};
    endcase
  endfunction : obs
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input int s);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm[s], exp, seen);
    end
  endtask : chk
  task automatic note(input int s, input logic [15:0] v);
    q.push_back('{s, v});
    -> look;
  endtask : note
  // oldest note is compared as soon as the driver flags a settled result
  always @(look) while (q.size() > 0) begin
    n = q.pop_front();
    chk(obs(n.s), n.v, n.s);
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  // bounded wait so a drive that never recovers cannot hang the run
  task automatic wait_ready();
    for (int i = 0; i < 100 && u_fhr_link_if.ready !== 1'b1; i++) step(1);
    note(3, 16'h1);
    step(1);
    note(14, 16'h1);
  endtask : wait_ready
  task automatic fault();
    logic [7:0] c;
    c = 8'($urandom);
    hq.push_back(c);
    @(posedge clk_sys) {evt_valid, evt_class, evt_code} <= {1'b1, 2'h3, c};
    @(posedge clk_sys) evt_valid <= 1'b0;
    step(1);
    note(0, 16'h1); note(1, 16'h1); note(7, 16'(FHR_DISP_FAULT)); note(8, {8'h0, c});
    note(15, 16'h1);
  endtask : fault
  task automatic close_out();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(32'h50ce3e3f));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    wait_ready();
    note(0, 16'h0); note(10, 16'h0); note(4, 16'h0);
    @(posedge clk_sys) {hour_tick, running} <= 2'b11;
    repeat (65535) @(posedge clk_sys);
    hour_tick <= 1'b0;
    step(2);
    note(4, HOUR_MAX); note(5, HOUR_MAX); note(6, {3'h0, DISP_MAX});
    note(13, {3'h0, DISP_MAX});
    @(posedge clk_sys) hour_tick <= 1'b1;
    @(posedge clk_sys) hour_tick <= 1'b0;
    step(2);
    note(4, 16'h0); note(6, 16'h0);
    note(5, 16'h0); note(13, 16'h0);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk_sys) {evt_valid, evt_class, evt_code, alarm_en} <= {1'b1, 2'(c), 8'($urandom), 1'b1};
      @(posedge clk_sys) evt_valid <= 1'b0;
      step(1);
      note(0, 16'h0); note(3, 16'h1); note(7, 16'(FHR_DISP_MSG));
    end
    note(2, 16'h1);
    @(posedge clk_sys) {req_key_reset, therm_inc, retry_inc} <= 3'b111;
    @(posedge clk_sys) {req_key_reset, therm_inc, retry_inc} <= 3'b000;
    step(3);
    note(3, 16'h1); note(11, 16'h1); note(12, 16'h1);
    @(posedge clk_sys) {comm_err, req_bus_reset} <= 2'b11;
    @(posedge clk_sys) req_bus_reset <= 1'b0;
    step(3);
    note(3, 16'h1);
    @(posedge clk_sys) comm_err <= 1'b0;
    fault();
    @(posedge clk_sys) req_key_reset <= 1'b1;
    @(posedge clk_sys) req_key_reset <= 1'b0;
    step(3);
    note(1, 16'h0); note(0, 16'h1); note(2, 16'h0); note(11, 16'h0); note(12, 16'h0);
    wait_ready();
    for (int i = 0; i < 8; i++) begin
      fault();
      @(posedge clk_sys) {req_bus_reset, req_start} <= 2'b11;
      @(posedge clk_sys) req_bus_reset <= 1'b0;
      step(3);
      note(1, 16'h0); note(0, 16'h1);
      note(16, 16'h0);
      @(posedge clk_sys) req_start <= 1'b0;
      wait_ready();
    end
    note(10, 16'h8);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys) hist_sel <= 3'(k);
      step(2);
      note(9, {8'h0, hq[8-k]});
    end
    // power cycle in mid-run: drive comes back tripped and recovers on its own
    @(posedge clk_sys) rst <= 1'b1;
    step(2);
    note(0, 16'h1); note(3, 16'h0); note(10, 16'h0);
    @(posedge clk_sys) rst <= 1'b0;
    wait_ready();
    close_out();
  end
  // watchdog sized well above the expected run of about 66000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
endmodule : tb
